// >>> hdl/sbad_defs.vh
/*
  Constants for the station number and bit-rate decoder: field widths,
  source selects, bit-rate codes and reset values.
  Assumes inclusion by its bare name from the decoder files.
*/
`ifndef SBAD_DEFS_VH
`define SBAD_DEFS_VH

// Station number limits
`define SBAD_STN_W        7
`define SBAD_STN_MIN      7'h01
`define SBAD_STN_MAX      7'h3F

// Switch field layout: [9:7] rate select, [6:0] address, switch 1 = MSB
`define SBAD_SW_W         10
`define SBAD_SW_RATE_HI   9
`define SBAD_SW_RATE_LO   7
`define SBAD_SW_ADR_HI    6
`define SBAD_SW_ADR_LO    0

// Uniform bit-rate code on the CAN side
`define SBAD_RATE_W       3
`define SBAD_RATE_20K     3'h0
`define SBAD_RATE_50K     3'h1
`define SBAD_RATE_100K    3'h2
`define SBAD_RATE_125K    3'h3
`define SBAD_RATE_250K    3'h4
`define SBAD_RATE_500K    3'h5
`define SBAD_RATE_800K    3'h6
`define SBAD_RATE_1M      3'h7

// Drive parameter digit width (one BCD digit) and its highest legal code
`define SBAD_DIGIT_W      4
`define SBAD_DRV_CODE_MAX 4'h6

// Servo parameter default code
`define SBAD_SERVO_DEF    3'h5

// Configuration source selects
`define SBAD_SRC_W        2
`define SBAD_SRC_PLC      2'h0
`define SBAD_SRC_DRIVE    2'h1
`define SBAD_SRC_SWITCH   2'h2
`define SBAD_SRC_SERVO    2'h3

`endif

// >>> hdl/sbad_sync.v
/*
  Two-stage synchroniser for a bundle of slow pin levels.
  Assumes inputs come from switches outside the mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sbad_sync #(
  parameter W = 10
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         reset_n,
  // Levels
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // First stage feeds only the second
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // sbad_sync

`default_nettype wire

// >>> hdl/sbad_decoder.v
/*
  Station number and CAN bit-rate decoder for a fieldbus station.
  Picks one of four configuration sources (PLC software settings, drive
  decimal parameters, card switch field, servo parameters), validates the
  station number and presents a uniform rate code and address to the CAN
  controller. Assumes parameters arrive from same-clock logic and switches
  arrive as raw pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbad_defs.vh"

// Summary of operation
// - Station number zero is never accepted and never used on the bus.
// - A station that sees its number taken by an earlier one goes silent.
// - PLC software settings load only on restart or program download.
// - The drive's thousands digit codes 0 to 6 pick 20k to 1000k.
// - A drive station number change applies at once; out of range fails.
// - The drive decode never yields the 800k rate.
// - The card reads a 10-bit switch field: 3 rate bits, 7 address bits.
// - Switch ON reads as one, and switch changes apply without restart.
// - Rate switches 000 to 111 pick 20k,50k,100k,125k,250k,500k,800k,1M.
// - Address switch one is the MSB and switch seven the LSB.
// - Switch addresses 0 and 64 to 127 are reserved and disable the card.
// - Servo rate codes 0 to 7 map to the eight rates, default code 5.
// - A servo without 800k runs 1000k on code 6; servo rates apply now.
module sbad_decoder (
  // Clock and reset
  input  wire                      mclk,
  input  wire                      reset_n,
  // Source selection
  input  wire [`SBAD_SRC_W-1:0]    config_source,
  input  wire                      servo_no_800k,
  // PLC local slave software settings
  input  wire [`SBAD_STN_W-1:0]    plc_station_number,
  input  wire [`SBAD_RATE_W-1:0]   plc_bit_rate,
  input  wire                      plc_restart,
  input  wire                      plc_download,
  // Drive parameters (station number binary, rate as thousands digit)
  input  wire [`SBAD_STN_W-1:0]    drive_station_number_param,
  input  wire [`SBAD_DIGIT_W-1:0]  drive_bit_rate_param,
  // Card switch field, raw pins
  input  wire [`SBAD_SW_W-1:0]     switch_field,
  // Servo parameters
  input  wire [`SBAD_STN_W-1:0]    servo_station_number_param,
  input  wire [`SBAD_RATE_W-1:0]   servo_bit_rate_param,
  input  wire                      servo_rate_written,
  // CAN controller status
  input  wire                      duplicate_detected,
  // CAN controller configuration
  output reg  [`SBAD_STN_W-1:0]    node_address,
  output reg  [`SBAD_RATE_W-1:0]   bit_rate_code,
  output reg                       address_valid,
  output reg                       rate_valid,
  output wire                      can_enable,
  output reg                       duplicate_lockout
);

  wire [`SBAD_SW_W-1:0]   sw_sync;
  reg  [`SBAD_STN_W-1:0]  plc_stn_reg;
  reg  [`SBAD_RATE_W-1:0] plc_rate_reg;
  reg  [`SBAD_RATE_W-1:0] servo_rate_reg;
  reg  [`SBAD_STN_W-1:0]  stn_next;
  reg  [`SBAD_RATE_W-1:0] rate_next;
  reg                     rate_ok_next;
  wire [`SBAD_STN_W-1:0]  sw_adr;
  wire [`SBAD_RATE_W-1:0] sw_rate;
  wire                    stn_ok;

  // Switches are mechanical and asynchronous to mclk
  sbad_sync #(
    .W (`SBAD_SW_W)
  ) u_sw_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (switch_field),
    .sync_out (sw_sync)
  );

  // ON reads one; the field is taken as live, no restart needed
  assign sw_rate = sw_sync[`SBAD_SW_RATE_HI:`SBAD_SW_RATE_LO];
  assign sw_adr  = sw_sync[`SBAD_SW_ADR_HI:`SBAD_SW_ADR_LO];

  // PLC settings are staged; only restart or download commits them
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      plc_stn_reg  <= {`SBAD_STN_W{1'b0}};
      plc_rate_reg <= `SBAD_SERVO_DEF;
    end
    else if (plc_restart || plc_download)
    begin
      plc_stn_reg  <= plc_station_number;
      plc_rate_reg <= plc_bit_rate;
    end
  end

  // Servo rate parameter holds its default code until first written
  always @(posedge mclk)
  begin
    if (!reset_n)
      servo_rate_reg <= `SBAD_SERVO_DEF;
    else if (servo_rate_written)
      servo_rate_reg <= servo_bit_rate_param;
  end

  // Source mux and per-source rate mapping
  always @*
  begin
    stn_next     = {`SBAD_STN_W{1'b0}};
    rate_next    = `SBAD_RATE_20K;
    rate_ok_next = 1'b1;
    case (config_source)
      `SBAD_SRC_PLC:
      begin
        stn_next  = plc_stn_reg;
        rate_next = plc_rate_reg;
      end
      `SBAD_SRC_DRIVE:
      begin
        stn_next = drive_station_number_param;
        // Digit 6 is 1000k; 800k cannot be reached here
        if (drive_bit_rate_param == `SBAD_DRV_CODE_MAX)
          rate_next = `SBAD_RATE_1M;
        else if (drive_bit_rate_param < `SBAD_DRV_CODE_MAX)
          rate_next = drive_bit_rate_param[`SBAD_RATE_W-1:0];
        else
          rate_ok_next = 1'b0;
      end
      `SBAD_SRC_SWITCH:
      begin
        stn_next  = sw_adr;
        rate_next = sw_rate;
      end
      `SBAD_SRC_SERVO:
      begin
        stn_next = servo_station_number_param;
        if (servo_no_800k && servo_rate_reg == `SBAD_RATE_800K)
          rate_next = `SBAD_RATE_1M;
        else
          rate_next = servo_rate_reg;
      end
      default:
      begin
        stn_next     = {`SBAD_STN_W{1'b0}};
        rate_ok_next = 1'b0;
      end
    endcase
  end

  // Zero and 64..127 are reserved for every source
  assign stn_ok = (stn_next >= `SBAD_STN_MIN) &&
                  (stn_next <= `SBAD_STN_MAX);

  // Registered outputs; a bad number forces address zero off the bus
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      node_address  <= {`SBAD_STN_W{1'b0}};
      bit_rate_code <= `SBAD_RATE_20K;
      address_valid <= 1'b0;
      rate_valid    <= 1'b0;
    end
    else
    begin
      node_address  <= stn_ok ? stn_next : {`SBAD_STN_W{1'b0}};
      bit_rate_code <= rate_next;
      address_valid <= stn_ok;
      rate_valid    <= rate_ok_next;
    end
  end

  // Once a clash is seen we stay off until reset, a restart or download,
  // or a change of station number; re-joining on our own would clash again
  always @(posedge mclk)
  begin
    if (!reset_n)
      duplicate_lockout <= 1'b0;
    else if (duplicate_detected)
      duplicate_lockout <= 1'b1;
    else if (plc_restart || plc_download ||
             node_address != stn_next)
      duplicate_lockout <= 1'b0;
  end

  // Controller runs only with a legal number, legal rate and no clash
  assign can_enable = address_valid && rate_valid &&
                      !duplicate_lockout;

endmodule // sbad_decoder

`default_nettype wire

// >>> sim/sbad_sw_panel.sv
/* Model of the card's ten configuration switches.
   Assumes the bench sets each switch group as a plain number. */
`timescale 1ns/1ps
`default_nettype none
module sbad_sw_panel (
  input  wire logic [2:0] rate_sw,
  input  wire logic [6:0] adr_sw,
  output logic      [9:0] switch_field
);
  // Switch 1 of each group is the top bit; ON reads as one
  assign switch_field = {rate_sw, adr_sw};
endmodule // sbad_sw_panel
`default_nettype wire

// >>> sim/sbad_decoder_chk.sv
/* Port checker for sbad_decoder.
   Assumes it is bound to every decoder instance. */
`timescale 1ns/1ps
`default_nettype none
module sbad_chk (
  input wire logic       mclk, reset_n, servo_no_800k, plc_restart,
  input wire logic       plc_download, servo_rate_written,
  input wire logic       duplicate_detected, address_valid, rate_valid,
  input wire logic       can_enable, duplicate_lockout,
  input wire logic [1:0] config_source,
  input wire logic [6:0] drive_station_number_param, node_address,
  input wire logic [2:0] servo_bit_rate_param, bit_rate_code,
  input wire logic [3:0] drive_bit_rate_param,
  input wire logic [9:0] switch_field
);
  logic [6:0] stn_q;
  logic [3:0] dig_q;
  logic [2:0] srv_q1, srv_q2;
  // Delayed copies stand in for $past on the parameter paths
  always_ff @(posedge mclk)
  begin
    stn_q <= drive_station_number_param;
    dig_q <= drive_bit_rate_param;
    srv_q1 <= servo_bit_rate_param;
    srv_q2 <= srv_q1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_addr_legal: assert property (address_valid |->
    node_address inside {[7'h01:7'h3F]}) else $error("bad valid address");
  a_dup_lock: assert property (duplicate_detected |=>
    duplicate_lockout && !can_enable) else $error("no lockout");
  a_can_gate: assert property (can_enable ==
    (address_valid && rate_valid && !duplicate_lockout))
    else $error("can_enable not gated");
  a_zero_off: assert property (node_address == 7'h00 |->
    !address_valid && !can_enable) else $error("zero address on bus");
  // Edge of release still shows reset values, so skip that attempt
  a_drive_rate: assert property ($past(reset_n) &&
    config_source == 2'h1 |=>
    rate_valid == (dig_q <= 4'h6) && bit_rate_code == (dig_q > 4'h6 ? 3'h0
    : dig_q == 4'h6 ? 3'h7 : dig_q[2:0])) else $error("drive rate");
  a_drive_stn: assert property ($past(reset_n) &&
    config_source == 2'h1 |=>
    address_valid == (stn_q inside {[7'h01:7'h3F]}) &&
    node_address == (address_valid ? stn_q : 7'h00)) else $error("drive stn");
  a_switch_map: assert property ((config_source == 2'h2 &&
    $stable(switch_field))[*4] |-> bit_rate_code == switch_field[9:7] &&
    address_valid == (switch_field[6:0] inside {[7'h01:7'h3F]}) &&
    node_address == (address_valid ? switch_field[6:0] : 7'h00))
    else $error("switch decode");
  a_servo_rate: assert property (config_source == 2'h3 &&
    servo_rate_written ##1 (config_source == 2'h3 &&
    $stable(servo_no_800k))[*2] |-> bit_rate_code ==
    (srv_q2 == 3'h6 && servo_no_800k ? 3'h7 : srv_q2)) else $error("servo");
  a_plc_hold: assert property ((config_source == 2'h0 &&
    !plc_restart && !plc_download)[*3] |=> $stable(node_address) &&
    $stable(bit_rate_code)) else $error("plc change without commit");
endmodule // sbad_chk
bind sbad_decoder sbad_chk u_chk (.*);
`default_nettype wire

// >>> sim/station_baud_address_decoder_tb.sv
/* Testbench for sbad_decoder and the switch panel model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`default_nettype none
module station_baud_address_decoder_tb;
  logic       mclk = 1'b0, rst_n = 1'b0, no8 = 1'b0, rs = 1'b0, dl = 1'b0;
  logic       wr = 1'b0, dup = 1'b0, av, rv, ce, lk;
  logic [1:0] src = 2'h1;
  logic [6:0] ps = 7'h00, ds = 7'h00, ss = 7'h00, adr = 7'h00, na;
  logic [2:0] pr = 3'h0, sr = 3'h0, bd = 3'h0, br;
  logic [3:0] dr = 4'h0;
  logic [9:0] sw;
  int err_total = 0, compares = 0;
  logic [6:0] stn [8] = '{7'h00, 7'h01, 7'h3F, 7'h40, 7'h05, 7'h45,
                          7'h7F, 7'h02};
  always #50 mclk = ~mclk;
  sbad_sw_panel u_sw (.rate_sw(bd), .adr_sw(adr), .switch_field(sw));
  sbad_decoder DUT (.mclk(mclk), .reset_n(rst_n), .config_source(src),
    .servo_no_800k(no8), .plc_station_number(ps), .plc_bit_rate(pr),
    .plc_restart(rs), .plc_download(dl), .drive_station_number_param(ds),
    .drive_bit_rate_param(dr), .switch_field(sw),
    .servo_station_number_param(ss), .servo_bit_rate_param(sr),
    .servo_rate_written(wr), .duplicate_detected(dup), .node_address(na),
    .bit_rate_code(br), .address_valid(av), .rate_valid(rv),
    .can_enable(ce), .duplicate_lockout(lk));
  task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic outs(logic [6:0] a, logic [2:0] r, logic v, logic e);
    chk("node_address", na, a);
    chk("bit_rate_code", br, r);
    chk("address_valid", av, v);
    chk("can_enable", ce, e);
  endtask
  // Drive digits 0..9 with legal and reserved station numbers
  task automatic t_drive();
    for (int d = 0; d < 10; d++)
    begin
      @(posedge mclk);
      src <= 2'h1;
      dr <= d[3:0];
      ds <= stn[d % 8];
      tick(1);
      outs(stn[d % 8] inside {[1:63]} ? stn[d % 8] : 7'h00,
        d > 6 ? 3'h0 : d == 6 ? 3'h7 : d[2:0],
        stn[d % 8] inside {[1:63]}, stn[d % 8] inside {[1:63]} && d < 7);
      chk("rate_valid", rv, d < 7);
    end
  endtask
  // Every rate setting, addresses on both sides of the legal range
  task automatic t_switch();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      src <= 2'h2;
      bd <= i[2:0];
      adr <= stn[i];
      // One edge past the sync latency lets the checker see a settled field
      tick(4);
      outs(stn[i] inside {[1:63]} ? stn[i] : 7'h00, i[2:0],
        stn[i] inside {[1:63]}, stn[i] inside {[1:63]});
    end
  endtask
  task automatic t_servo();
    @(posedge mclk);
    src <= 2'h3;
    ss <= 7'h3F;
    tick(1);
    outs(7'h3F, 3'h5, 1'b1, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      sr <= i[2:0];
      no8 <= i[3];
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      tick(1);
      chk("servo rate", br, i == 14 ? 3'h7 : i[2:0]);
    end
  endtask
  task automatic commit(logic d);
    @(posedge mclk);
    rs <= !d;
    dl <= d;
    @(posedge mclk);
    rs <= 1'b0;
    dl <= 1'b0;
    tick(1);
  endtask
  // Staged settings must wait for restart or download
  task automatic t_plc();
    @(posedge mclk);
    src <= 2'h0;
    ps <= 7'h2A;
    pr <= 3'h3;
    tick(2);
    chk("address_valid", av, 1'b0);
    commit(1'b0);
    outs(7'h2A, 3'h3, 1'b1, 1'b1);
    @(posedge mclk);
    ps <= 7'h10;
    tick(3);
    chk("node_address", na, 7'h2A);
    commit(1'b1);
    chk("node_address", na, 7'h10);
  endtask
  task automatic t_dup();
    @(posedge mclk);
    src <= 2'h1;
    dr <= 4'h4;
    ds <= 7'h07;
    @(posedge mclk);
    dup <= 1'b1;
    @(posedge mclk);
    dup <= 1'b0;
    tick(3);
    chk("duplicate_lockout", lk, 1'b1);
    chk("can_enable", ce, 1'b0);
    @(posedge mclk);
    ds <= 7'h08;
    tick(2);
    outs(7'h08, 3'h4, 1'b1, 1'b1);
  endtask
  // Mid-run reset returns outputs to zero and the servo rate to default
  task automatic t_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    src <= 2'h3;
    tick(2);
    outs(7'h00, 3'h0, 1'b0, 1'b0);
    chk("rate_valid", rv, 1'b0);
    chk("duplicate_lockout", lk, 1'b0);
    @(posedge mclk);
    rst_n <= 1'b1;
    tick(1);
    outs(7'h3F, 3'h5, 1'b1, 1'b1);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    tick(11);
    outs(7'h00, 3'h0, 1'b0, 1'b0);
    @(posedge mclk);
    rst_n <= 1'b1;
    t_drive();
    t_switch();
    t_servo();
    t_plc();
    t_dup();
    t_reset();
    conclude();
  end
  // Whole run is about 150 cycles; this allows ample slack
  initial
  begin
    #1000000;
    err_total++;
    conclude();
  end
endmodule // station_baud_address_decoder_tb
`default_nettype wire
